// [design/lcd_ctrl_pkg.sv]
/*
 * Constants, register addresses and carrier types for the segment LCD
 * control block. Assumes an 8-bit special function register port driven
 * by the on-chip processor in the same clock domain.
 */
// Operation
// - The voltage source select bit resets to zero so the charge pump is used by default.
// - With the select bit set, levels come from the resistor ladder and no bias compensation applies.
// - In battery low-power mode the display runs only with sleep-off clear and enable set.
// - Turning the display off leaves all configuration and segment memory unchanged.
// - The first sixteen segment lines are always in segment use.
// - With four-way multiplexing the pins shared with commons two and three are not segments.
// - Each shared segment pin is a segment only when its bit is set in a segment enable register.
// - All frame divider bits set with 2048 Hz clock and 4x multiplexing gives a 64 Hz frame.
// - While hold is set the previous pattern stays on the glass until hold clears.
// - A pointer write with top bit set copies the data register into segment memory.
// - A pointer write with top bit clear loads the data register from segment memory.
// - Each memory byte holds an even segment in its low nibble and the next odd in its high.
package lcd_ctrl_pkg;
	localparam logic [7:0] ADDR_LCD_CONFIG = 8'h95;
	localparam logic [7:0] ADDR_LCD_CLOCK = 8'h96;
	localparam logic [7:0] ADDR_SEG_EN_LOW = 8'h97;
	localparam logic [7:0] ADDR_BIAS_CONFIG = 8'h9C;
	localparam logic [7:0] ADDR_SEG_POINTER = 8'hAC;
	localparam logic [7:0] ADDR_SEG_DATA = 8'hAE;
	localparam logic [7:0] ADDR_UPDATE_HOLD = 8'hB1;
	localparam logic [7:0] ADDR_SEG_EN_HIGH = 8'hED;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// lcd_config fields
	localparam int BIT_DISPLAY_ENABLE = 7;
	localparam int BIT_SLEEP_OFF = 6;
	localparam int BIT_MUX_HI = 1;
	localparam int BIT_MUX_LO = 0;
	// lcd_bias_config fields
	localparam int BIT_VSRC_SELECT = 7;
	localparam int BIT_LEVEL_TOP = 5;
	// pointer and hold fields
	localparam int BIT_PTR_WRITE = 7;
	localparam int BIT_HOLD = 0;
	localparam int SEG_MEM_DEPTH = 15;
	localparam int SEG_LINES = 29;
	localparam int DEDICATED_SEGS = 16;
	localparam int SHARED_COM3_SEG = 27;
	localparam int SHARED_COM2_SEG = 28;
	localparam logic [1:0] MUX_FOUR = 2'h3;
	localparam logic [3:0] FD_ALL = 4'hF;
	localparam int LCD_CLK_HZ = 2048;
	localparam int FRAME_HZ_FD_ALL = 64;

	// Special function register access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	// Settings seen by the analog driver
	typedef struct packed {
		logic display_on;
		logic pump_enable;
		logic ladder_select;
		logic compensate;
		logic [5:0] contrast_level;
		logic [1:0] multiplex_select;
		logic [3:0] frame_divider;
	} drive_cfg_t;
endpackage : lcd_ctrl_pkg

// [design/seg_memory.sv]
/*
 * Segment data memory with a frozen display copy.
 * Assumes single-cycle write and read requests from the register logic.
 */
`timescale 1ns/10ps
module seg_memory
	import lcd_ctrl_pkg::*;
#(
	parameter int DEPTH = SEG_MEM_DEPTH
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Access
	input wire logic wr_en,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	// Display copy
	input wire logic hold,
	output logic [DEPTH*8-1:0] shown
);
	import lcd_ctrl_pkg::*;
	logic [7:0] mem [DEPTH];
	logic [7:0] next_mem [DEPTH];
	logic [DEPTH*8-1:0] next_shown;

	// Write path and display snapshot
	always_comb
	begin
		for (int i = 0; i < DEPTH; i++)
		begin
			next_mem[i] = mem[i];
			if (wr_en && addr == 4'(i))
				next_mem[i] = wdata;
			// Glass follows memory only while not held
			next_shown[i*8 +: 8] = hold ? shown[i*8 +: 8] : mem[i];
		end
	end

	// Memory has no dependence on display state, so it survives off
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= RESET_BYTE;
			shown <= '0;
		end
		else
		begin
			mem <= next_mem;
			shown <= next_shown;
		end
	end

	// Out of range addresses read zero
	assign rdata = (int'(addr) < DEPTH) ? mem[addr] : RESET_BYTE;
endmodule : seg_memory

// [design/segment_lcd_control.sv]
/*
 * Segment LCD control: configuration registers, voltage source and
 * power gating, pin assignment and indirect segment memory access.
 * The waveform generator, charge pump and resistor ladder switches sit
 * in the analog driver, which takes the drive settings and the
 * registered per-line phases from here.
 * Assumes the processor register port is synchronous to ref_clk, with
 * combinational reads and one-cycle write strobes, and that the supply
 * monitor's power mode flag is already in this clock domain.
 */
`timescale 1ns/10ps
module segment_lcd_control
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire lcd_ctrl_pkg::sfr_req_t sfr,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// Power mode from the supply monitor
	input wire logic battery_low_power_mode,
	// Driver settings and pin use
	output lcd_ctrl_pkg::drive_cfg_t drive,
	output logic [lcd_ctrl_pkg::SEG_LINES-1:0] seg_pin_is_lcd,
	output logic com2_drive,
	output logic com3_drive,
	// Per segment line, four common phases
	output logic [lcd_ctrl_pkg::SEG_LINES*4-1:0] seg_phase
);
	import lcd_ctrl_pkg::*;

	// Software visible registers
	logic [7:0] lcd_config, next_lcd_config;
	logic [7:0] lcd_clock_reg, next_lcd_clock_reg;
	logic [7:0] segment_enable_low, next_segment_enable_low;
	logic [7:0] segment_enable_high, next_segment_enable_high;
	logic [7:0] lcd_bias_config, next_lcd_bias_config;
	logic [7:0] segment_pointer_reg, next_segment_pointer_reg;
	logic [7:0] segment_data_reg, next_segment_data_reg;
	logic [7:0] update_hold_reg, next_update_hold_reg;
	// Segment memory side
	logic mem_wr;
	logic mem_rd;
	logic [3:0] mem_addr;
	logic [7:0] mem_rdata;
	// Shown copy of memory, frozen while hold is set
	logic [SEG_MEM_DEPTH*8-1:0] shown;
	// Decoded controls
	logic ptr_wr;
	logic display_on;
	logic four_mux;
	logic vsrc_ladder;
	// Phases before the output register
	logic [SEG_LINES*4-1:0] next_seg_phase;

	// Pointer decode; the top bit picks the direction of the transfer
	assign ptr_wr = sfr.wr && sfr.addr == ADDR_SEG_POINTER;
	assign mem_wr = ptr_wr && sfr.wdata[BIT_PTR_WRITE];
	assign mem_rd = ptr_wr && !sfr.wdata[BIT_PTR_WRITE];
	// Byte address rides in the low bits of the same pointer write
	assign mem_addr = sfr.wdata[3:0];

	// Register writes and pointer side effects
	always_comb
	begin
		next_lcd_config = lcd_config;
		next_lcd_clock_reg = lcd_clock_reg;
		next_segment_enable_low = segment_enable_low;
		next_segment_enable_high = segment_enable_high;
		next_lcd_bias_config = lcd_bias_config;
		next_segment_pointer_reg = segment_pointer_reg;
		next_segment_data_reg = segment_data_reg;
		next_update_hold_reg = update_hold_reg;
		// Unmapped addresses fall through and change nothing
		if (sfr.wr)
		begin
			unique case (sfr.addr)
				ADDR_LCD_CONFIG: next_lcd_config = sfr.wdata;
				ADDR_LCD_CLOCK: next_lcd_clock_reg = sfr.wdata;
				ADDR_SEG_EN_LOW: next_segment_enable_low = sfr.wdata;
				ADDR_SEG_EN_HIGH: next_segment_enable_high = sfr.wdata;
				ADDR_BIAS_CONFIG: next_lcd_bias_config = sfr.wdata;
				ADDR_SEG_POINTER: next_segment_pointer_reg = sfr.wdata;
				ADDR_SEG_DATA: next_segment_data_reg = sfr.wdata;
				ADDR_UPDATE_HOLD: next_update_hold_reg = sfr.wdata;
				default: ;
			endcase
		end
		// Read access: data register takes the addressed byte
		if (mem_rd)
			next_segment_data_reg = mem_rdata;
	end

	// Configuration state; nothing here clears on display off
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			lcd_config <= RESET_BYTE;
			lcd_clock_reg <= RESET_BYTE;
			segment_enable_low <= RESET_BYTE;
			segment_enable_high <= RESET_BYTE;
			lcd_bias_config <= RESET_BYTE;
			segment_pointer_reg <= RESET_BYTE;
			segment_data_reg <= RESET_BYTE;
			update_hold_reg <= RESET_BYTE;
		end
		else
		begin
			lcd_config <= next_lcd_config;
			lcd_clock_reg <= next_lcd_clock_reg;
			segment_enable_low <= next_segment_enable_low;
			segment_enable_high <= next_segment_enable_high;
			lcd_bias_config <= next_lcd_bias_config;
			segment_pointer_reg <= next_segment_pointer_reg;
			segment_data_reg <= next_segment_data_reg;
			update_hold_reg <= next_update_hold_reg;
		end
	end

	// Segment memory, addressed by the low pointer bits of the write
	seg_memory #(
		.DEPTH(SEG_MEM_DEPTH)
	) u_seg_memory (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr_en(mem_wr),
		.addr(mem_addr),
		.wdata(segment_data_reg),
		.rdata(mem_rdata),
		.hold(update_hold_reg[BIT_HOLD]),
		.shown(shown)
	);

	// Register read mux; unmapped addresses leave sfr_hit low
	always_comb
	begin
		// Reads need no strobe; the read qualifier bit goes unused
		sfr_hit = 1'b1;
		unique case (sfr.addr)
			ADDR_LCD_CONFIG: sfr_rdata = lcd_config;
			ADDR_LCD_CLOCK: sfr_rdata = lcd_clock_reg;
			ADDR_SEG_EN_LOW: sfr_rdata = segment_enable_low;
			ADDR_SEG_EN_HIGH: sfr_rdata = segment_enable_high;
			ADDR_BIAS_CONFIG: sfr_rdata = lcd_bias_config;
			ADDR_SEG_POINTER: sfr_rdata = segment_pointer_reg;
			ADDR_SEG_DATA: sfr_rdata = segment_data_reg;
			ADDR_UPDATE_HOLD: sfr_rdata = update_hold_reg;
			default:
			begin
				sfr_rdata = RESET_BYTE;
				sfr_hit = 1'b0;
			end
		endcase
	end

	// Battery mode gating; outside it the enable bit alone decides
	assign display_on = lcd_config[BIT_DISPLAY_ENABLE] &&
		!(battery_low_power_mode && lcd_config[BIT_SLEEP_OFF]);
	// Four-way decode, shared by the commons and the pin use
	assign four_mux = lcd_config[BIT_MUX_HI:BIT_MUX_LO] == MUX_FOUR;

	// Voltage source; reset leaves this clear, so the pump is the default
	assign vsrc_ladder = lcd_bias_config[BIT_VSRC_SELECT];

	// Driver settings; pump idles with the display to save power
	always_comb
	begin
		drive.display_on = display_on;
		// Ladder levels are fixed off chip, so no bias compensation there
		drive.ladder_select = vsrc_ladder;
		drive.pump_enable = display_on && !vsrc_ladder;
		drive.compensate = display_on && !vsrc_ladder;
		// Contrast only matters while the pump makes the levels
		drive.contrast_level = lcd_bias_config[BIT_LEVEL_TOP:0];
		drive.multiplex_select = lcd_config[BIT_MUX_HI:BIT_MUX_LO];
		// Frame rate divides in the analog timing block from these bits
		drive.frame_divider = lcd_clock_reg[3:0];
	end

	// Commons two and three claim their shared pins at four-way only;
	// fewer commons leave those pins free for segment use
	assign com2_drive = four_mux;
	assign com3_drive = four_mux;

	// Pin assignment and phase fan-out, one entry per segment line
	for (genvar s = 0; s < SEG_LINES; s++)
	begin : g_seg
		if (s < DEDICATED_SEGS)
		begin : g_ded
			// No software setting needed on these lines
			assign seg_pin_is_lcd[s] = 1'b1;
		end
		else if (s == SHARED_COM3_SEG || s == SHARED_COM2_SEG)
		begin : g_shr
			// Common use wins over a segment enable
			assign seg_pin_is_lcd[s] = !four_mux &&
				segment_enable_high[s - DEDICATED_SEGS - 8];
		end
		else if (s < DEDICATED_SEGS + 8)
		begin : g_lo
			// Low enable register covers the first eight shared lines
			assign seg_pin_is_lcd[s] = segment_enable_low[s - DEDICATED_SEGS];
		end
		else
		begin : g_hi
			// High enable register covers the rest
			assign seg_pin_is_lcd[s] = segment_enable_high[s - DEDICATED_SEGS - 8];
		end
		// Even line low nibble, odd line high nibble
		assign next_seg_phase[s*4 +: 4] = display_on ?
			shown[(s/2)*8 + (s%2)*4 +: 4] : 4'h0;
	end

	// Phase register; the glass sees a clean word one edge after a change
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			seg_phase <= '0;
		else
			seg_phase <= next_seg_phase;
	end
endmodule : segment_lcd_control

// [verif/lcd_glass.sv]
/* Behavioural glass on the common and segment lines.
   Assumes settings and phases straight from the LCD control block. */
`timescale 1ns/10ps
module lcd_glass
(
	// Driver settings and pin use
	input wire lcd_ctrl_pkg::drive_cfg_t drive,
	input wire logic [28:0] seg_pin_is_lcd,
	input wire logic [115:0] seg_phase,
	// Segments seen dark
	output logic [115:0] lit
);
	import lcd_ctrl_pkg::*;
	// Dark only on powered LCD pins; no pin means no segment
	always_comb
	begin
		for (int n = 0; n < SEG_LINES; n++)
			lit[n*4+:4] = seg_phase[n*4+:4] &
				{4{drive.display_on & seg_pin_is_lcd[n]}};
	end
endmodule : lcd_glass

// [verif/lcd_ctrl_asserts.sv]
/* Port checks of the LCD control block.
   Bound to segment_lcd_control; one clock, async reset. */
`timescale 1ns/10ps
module lcd_ctrl_asserts
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire lcd_ctrl_pkg::sfr_req_t sfr,
	input wire logic battery_low_power_mode,
	// Driver side
	input wire lcd_ctrl_pkg::drive_cfg_t drive,
	input wire logic [28:0] seg_pin_is_lcd,
	input wire logic com2_drive,
	input wire logic com3_drive,
	input wire logic [115:0] seg_phase
);
	import lcd_ctrl_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// A write taken at this edge
	sequence s_wr(logic [7:0] a);
		sfr.wr && sfr.addr == a;
	endsequence
	a_ladder_sel: assert property (s_wr(ADDR_BIAS_CONFIG) |=>
		drive.ladder_select == $past(sfr.wdata[7])) else $error("ladder");
	a_ladder_nocomp: assert property (drive.ladder_select |->
		!drive.compensate) else $error("compensation on ladder");
	a_battery_gate: assert property (s_wr(ADDR_LCD_CONFIG) ##1
		battery_low_power_mode |-> drive.display_on ==
		($past(sfr.wdata[7]) && !$past(sfr.wdata[6])))
		else $error("battery gating");
	a_dedicated_segs: assert property (
		seg_pin_is_lcd[15:0] == 16'hFFFF) else $error("dedicated");
	a_four_mux: assert property (drive.multiplex_select == MUX_FOUR |->
		com2_drive && com3_drive && seg_pin_is_lcd[28:27] == 2'h0)
		else $error("four-way commons");
	a_seg_enable: assert property (s_wr(ADDR_SEG_EN_LOW) |=>
		seg_pin_is_lcd[23:16] == $past(sfr.wdata)) else $error("enable");
	a_frame_div: assert property (s_wr(ADDR_LCD_CLOCK) |=>
		drive.frame_divider == $past(sfr.wdata[3:0])) else $error("div");
	a_off_blank: assert property (!drive.display_on &&
		!$past(drive.display_on) |-> seg_phase == '0) else $error("blank");
endmodule : lcd_ctrl_asserts
bind segment_lcd_control lcd_ctrl_asserts u_chk(.ref_clk(ref_clk),
	.rst(rst), .sfr(sfr), .battery_low_power_mode(battery_low_power_mode),
	.drive(drive), .seg_pin_is_lcd(seg_pin_is_lcd), .com2_drive(com2_drive),
	.com3_drive(com3_drive), .seg_phase(seg_phase));

// [verif/tb.sv]
/* Self-checking bench for the LCD control block.
   Assumes a 100 MHz clock and the glass model beside it. */
`timescale 1ns/10ps
module tb;
	import lcd_ctrl_pkg::*;
	logic ref_clk;
	logic rst;
	sfr_req_t sfr;
	logic [7:0] sfr_rdata;
	logic sfr_hit;
	logic battery_low_power_mode;
	drive_cfg_t drive;
	logic [28:0] seg_pin_is_lcd;
	logic com2_drive;
	logic com3_drive;
	logic [115:0] seg_phase;
	logic [115:0] lit;
	int mismatches = 0;
	int cmp_count = 0;
	segment_lcd_control u_dut(.ref_clk(ref_clk), .rst(rst), .sfr(sfr),
		.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .drive(drive),
		.battery_low_power_mode(battery_low_power_mode),
		.seg_pin_is_lcd(seg_pin_is_lcd), .com2_drive(com2_drive),
		.com3_drive(com3_drive), .seg_phase(seg_phase));
	lcd_glass u_glass(.drive(drive), .seg_pin_is_lcd(seg_pin_is_lcd),
		.seg_phase(seg_phase), .lit(lit));
	// Clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Write lands at the second edge; #1 lets it settle before checks
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk);
		sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		sfr.wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] e, logic h);
		@(posedge ref_clk);
		sfr.addr <= a;
		#1;
		chk("read", e, sfr_rdata);
		chk("hit", h, sfr_hit);
	endtask : rd
	task automatic settle(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	// Watchdog, far beyond the roughly 72 cycles needed
	initial
	begin
		settle(5000);
		mismatches++;
		finish_test();
	end
	initial
	begin
		rst = 1'b1;
		sfr = '0;
		battery_low_power_mode = 1'b0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk("ladder", 0, drive.ladder_select);
		chk("pins", 29'h000FFFF, seg_pin_is_lcd);
		rd(ADDR_BIAS_CONFIG, 8'h00, 1'b1);
		rd(8'h90, 8'h00, 1'b0);
		wr(ADDR_BIAS_CONFIG, 8'hBF);
		chk("ladder", 1, drive.ladder_select);
		chk("comp", 0, drive.compensate);
		chk("level", 8'h3F, drive.contrast_level);
		wr(ADDR_SEG_EN_LOW, 8'h0F);
		wr(ADDR_SEG_EN_HIGH, 8'h1F);
		chk("pins", 29'h1F0FFFFF, seg_pin_is_lcd);
		wr(ADDR_LCD_CONFIG, 8'h03);
		wr(ADDR_LCD_CLOCK, 8'h0F);
		chk("pins", 29'h070FFFFF, seg_pin_is_lcd);
		chk("coms", 2'h3, {com2_drive, com3_drive});
		chk("div", {MUX_FOUR, FD_ALL},
			{drive.multiplex_select, drive.frame_divider});
		@(posedge ref_clk) battery_low_power_mode <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_LCD_CONFIG, {i[1:0], 6'h03});
			chk("on", i == 2, drive.display_on);
		end
		wr(ADDR_LCD_CONFIG, 8'h83);
		wr(ADDR_UPDATE_HOLD, 8'h01);
		wr(ADDR_SEG_DATA, 8'h5A);
		wr(ADDR_SEG_POINTER, 8'h87);
		settle(3);
		chk("frozen", 8'h00, seg_phase[63:56]);
		wr(ADDR_UPDATE_HOLD, 8'h00);
		settle(3);
		chk("shown", 8'h5A, seg_phase[63:56]);
		chk("glass", 8'h5A, lit[63:56]);
		wr(ADDR_SEG_DATA, 8'hA5);
		wr(ADDR_SEG_POINTER, 8'h8E);
		wr(ADDR_SEG_POINTER, 8'h8F);
		wr(ADDR_SEG_POINTER, 8'h0E);
		rd(ADDR_SEG_DATA, 8'hA5, 1'b1);
		wr(ADDR_SEG_POINTER, 8'h0F);
		rd(ADDR_SEG_DATA, 8'h00, 1'b1);
		settle(3);
		chk("line 28", 4'h5, seg_phase[115:112]);
		wr(ADDR_LCD_CONFIG, 8'hC3);
		settle(2);
		chk("blank", 8'h00, seg_phase[63:56]);
		rd(ADDR_LCD_CONFIG, 8'hC3, 1'b1);
		rd(ADDR_SEG_EN_HIGH, 8'h1F, 1'b1);
		wr(ADDR_SEG_POINTER, 8'h07);
		rd(ADDR_SEG_DATA, 8'h5A, 1'b1);
		@(posedge ref_clk) battery_low_power_mode <= 1'b0;
		settle(3);
		chk("back", 8'h5A, seg_phase[63:56]);
		// Mid-run reset brings the source back to the pump
		@(posedge ref_clk) rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk("ladder", 0, drive.ladder_select);
		rd(ADDR_BIAS_CONFIG, 8'h00, 1'b1);
		wr(ADDR_LCD_CONFIG, 8'h80);
		chk("pump", 1, drive.pump_enable);
		chk("comp", 1, drive.compensate);
		finish_test();
	end
endmodule : tb
